//--- core/remote_read_access_port.sv
// remote host read port: instruction memory, data memory, program counter view, config register
//
// Summary of operation
// - Instruction word is read as two byte accesses, low byte first, then high byte.
// - Instruction address increments only after the high byte has been read.
// - Buffered instruction read: release one T after ack low, ack high n_iw+2 T later.
// - Buffered instruction byte driven one T after release, valid n_iw+1 T before ack.
// - Buffered read: data and release held until host lifts both strobes.
// - Next instruction address driven 0.5 to 1.5 T after release falls.
// - Both strobes low are answered by pulling ack low.
// - Latched non-instruction reads: release rises n_lw+1 T after ack falls.
// - Latched counter/config read: ack two T after release, data one T after release.
// - Latched counter/config data held half a T after ack rises.
// - Latched read drops release one T after ack rises, ignoring strobes.
// - Latched data read: memory strobe one T after release, ack n_dw+1 T later.
// - Latched data read: memory strobe rises half a T after ack rises.
// - Latched data read: ack rises n_dw+2 T after release rises.
// - Instruction address bus released before release rises, retaken only after it falls.
`timescale 1ns/10ps
`default_nettype none
module remote_read_access_port
  import remote_read_pkg::*;
(
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  // host request and mode
  input  wire remote_req_type       i_req,
  input  wire logic                 i_latched_mode,
  input  wire wait_cfg_type         i_wait,
  // local sources of read data
  input  wire logic [2*BYTE_W-1:0]  i_instruction_memory_rdata,
  input  wire logic [BYTE_W-1:0]    i_data_memory_rdata,
  input  wire logic [BYTE_W-1:0]    i_pc_view,
  input  wire logic [BYTE_W-1:0]    i_config_reg,
  // handshake to host
  output var  logic                 o_ack_n,
  output var  logic                 o_local_bus_release,
  // address/data bus
  output var  logic [BYTE_W-1:0]    o_ad_data,
  output var  logic                 o_ad_oe,
  // instruction address bus
  output var  logic [IADDR_W-1:0]   o_instr_address,
  output var  logic                 o_addr_oe,
  // data memory read strobe
  output var  logic                 o_mem_read_n
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE_LCL, ST_LCL_ON, ST_POST_ACK, ST_HOLD_BUF, ST_BUF_END, ST_RESTORE, ST_REARM
  } state_type;

  localparam int T1 = T_CYC;
  localparam int AK2 = 2 * T_CYC;
  localparam int HC = HALF_T_CYC;

  // wait count in T-states to clock cycles
  function automatic logic [7:0] to_cycles(input logic [CNT_W-1:0] n);
    to_cycles = 8'(n * T_CYC);
  endfunction : to_cycles

  state_type            state_reg, state_next;
  logic [CNT_W-1:0]     cnt_reg, cnt_next;
  logic                 ack_n_reg, ack_n_next;
  logic                 lcl_reg, lcl_next;
  logic [BYTE_W-1:0]    ad_data_reg, ad_data_next;
  logic                 ad_oe_reg, ad_oe_next;
  logic                 addr_oe_reg, addr_oe_next;
  logic                 rd_n_reg, rd_n_next;
  logic [IADDR_W-1:0]   ia_reg, ia_next;
  logic                 high_reg, high_next;
  select_type           sel_reg, sel_next;
  logic                 latched_reg, latched_next;
  logic                 restart;
  logic                 t_tick;
  logic                 h_tick;
  logic                 strobes_low;
  logic                 strobes_high;
  logic [CNT_W-1:0]     pre_len;
  logic [CNT_W-1:0]     ack_len;
  logic [BYTE_W-1:0]    read_byte;

  tstate_divider #(
    .PERIOD (T_CYC),
    .HALF   (HALF_T_CYC)
  ) u_div (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_restart (restart),
    .o_t_tick  (t_tick),
    .o_h_tick  (h_tick)
  );

  // strobe decode and per-target lengths
  assign strobes_low  = !i_req.access_n && !i_req.read_n;
  assign strobes_high = i_req.access_n && i_req.read_n;
  assign pre_len = (!latched_reg && sel_reg == SEL_INSTRUCTION_MEMORY) ? 4'h1
                                                         : {1'b0, i_wait.local_w} + 4'h1;

  // ack distance from release, per target
  always_comb begin
    unique case (sel_reg)
      SEL_INSTRUCTION_MEMORY: ack_len = {1'b0, i_wait.instr} + 4'h2;
      SEL_DATA_MEMORY: ack_len = {1'b0, i_wait.data} + 4'h2;
      SEL_PC,
      SEL_CFG:  ack_len = 4'h2;
    endcase
  end

  // returned byte; instruction word goes out low byte first
  always_comb begin
    unique case (sel_reg)
      SEL_INSTRUCTION_MEMORY: read_byte = high_reg ? i_instruction_memory_rdata[15:8] : i_instruction_memory_rdata[7:0];
      SEL_PC:   read_byte = i_pc_view;
      SEL_CFG:  read_byte = i_config_reg;
      SEL_DATA_MEMORY: read_byte = i_data_memory_rdata;
    endcase
  end

  // access sequencer
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    ack_n_next   = ack_n_reg;
    lcl_next     = lcl_reg;
    ad_data_next = ad_data_reg;
    ad_oe_next   = ad_oe_reg;
    addr_oe_next = addr_oe_reg;
    rd_n_next    = rd_n_reg;
    ia_next      = ia_reg;
    high_next    = high_reg;
    sel_next     = sel_reg;
    latched_next = latched_reg;
    restart      = 1'b0;
    // data memory byte follows the memory while its strobe is low
    if (!rd_n_reg) begin
      ad_data_next = i_data_memory_rdata;
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (strobes_low) begin
          ack_n_next   = 1'b0;
          sel_next     = i_req.select;
          latched_next = i_latched_mode;
          addr_oe_next = 1'b0;
          restart      = 1'b1;
          cnt_next     = '0;
          state_next   = ST_PRE_LCL;
        end
      end
      ST_PRE_LCL: begin
        if (t_tick) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_next == pre_len) begin
            lcl_next   = 1'b1;
            cnt_next   = '0;
            state_next = ST_LCL_ON;
          end
        end
      end
      ST_LCL_ON: begin
        if (t_tick) begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_next == 4'h1) begin
            ad_oe_next = 1'b1;
            if (sel_reg == SEL_DATA_MEMORY) begin
              rd_n_next = 1'b0;
            end else begin
              ad_data_next = read_byte;
            end
          end
          if (cnt_next == ack_len) begin
            ack_n_next = 1'b1;
            cnt_next   = '0;
            if (sel_reg == SEL_INSTRUCTION_MEMORY) begin
              high_next = !high_reg;
              if (high_reg) begin
                ia_next = ia_reg + 1'b1;
              end
            end
            state_next = latched_reg ? ST_POST_ACK : ST_HOLD_BUF;
          end
        end
      end
      ST_POST_ACK: begin
        // latched style ends on its own, strobes are not awaited
        if (h_tick) begin
          rd_n_next  = 1'b1;
          ad_oe_next = 1'b0;
        end
        if (t_tick) begin
          lcl_next   = 1'b0;
          state_next = ST_RESTORE;
        end
      end
      ST_HOLD_BUF: begin
        if (strobes_high) begin
          ad_oe_next = 1'b0;
          rd_n_next  = 1'b1;
          state_next = ST_BUF_END;
        end
      end
      ST_BUF_END: begin
        // release waits for the T-state edge, so a late host costs a T-state
        if (t_tick) begin
          lcl_next   = 1'b0;
          state_next = ST_RESTORE;
        end
      end
      ST_RESTORE: begin
        if (h_tick) begin
          addr_oe_next = 1'b1;
          state_next   = ST_REARM;
        end
      end
      ST_REARM: begin
        // a latched host may still hold its strobes; no retrigger until lifted
        if (strobes_high) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= '0;
      ack_n_reg   <= 1'b1;
      lcl_reg     <= 1'b0;
      ad_data_reg <= DATA_RESET;
      ad_oe_reg   <= 1'b0;
      addr_oe_reg <= 1'b1;
      rd_n_reg    <= 1'b1;
      ia_reg      <= IADDR_RESET;
      high_reg    <= 1'b0;
      sel_reg     <= SEL_INSTRUCTION_MEMORY;
      latched_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      ack_n_reg   <= ack_n_next;
      lcl_reg     <= lcl_next;
      ad_data_reg <= ad_data_next;
      ad_oe_reg   <= ad_oe_next;
      addr_oe_reg <= addr_oe_next;
      rd_n_reg    <= rd_n_next;
      ia_reg      <= ia_next;
      high_reg    <= high_next;
      sel_reg     <= sel_next;
      latched_reg <= latched_next;
    end
  end

  // outputs straight from flip-flops
  assign o_ack_n             = ack_n_reg;
  assign o_local_bus_release = lcl_reg;
  assign o_ad_data           = ad_data_reg;
  assign o_ad_oe             = ad_oe_reg;
  assign o_instr_address     = ia_reg;
  assign o_addr_oe           = addr_oe_reg;
  assign o_mem_read_n        = rd_n_reg;

  // helper counters: cycles since ack fell, release rose, release fell
  logic [7:0] ackf_cyc, lclr_cyc, lclf_cyc;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ackf_cyc <= '0;
      lclr_cyc <= '0;
      lclf_cyc <= '0;
    end else begin
      ackf_cyc <= ack_n_reg ? 8'h00 : ackf_cyc + 8'h01;
      lclr_cyc <= lcl_reg ? lclr_cyc + 8'h01 : 8'h00;
      lclf_cyc <= lcl_reg ? 8'h00 : lclf_cyc + 8'h01;
    end
  end

  ack_take_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_IDLE && strobes_low) |=> $fell(o_ack_n)) else $error("ack not pulled low on request");
  lcl_rise_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_local_bus_release) |-> ackf_cyc == to_cycles(pre_len)) else $error("release rose at wrong time");
  instruction_memory_ack_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($rose(o_ack_n) && sel_reg == SEL_INSTRUCTION_MEMORY) |-> lclr_cyc == to_cycles({1'b0, i_wait.instr} + 4'h2))
    else $error("instruction ack at wrong time");
  data_drive_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_ad_oe) |-> lclr_cyc == 8'(T_CYC)) else $error("data not driven one T after release");
  buf_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_HOLD_BUF && !strobes_high) |=> o_local_bus_release && o_ad_oe)
    else $error("buffered data dropped before strobe release");
  addr_back_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_addr_oe) |-> lclf_cyc >= 8'(HALF_T_CYC) && lclf_cyc <= 8'(T_CYC + HALF_T_CYC))
    else $error("instruction address restored out of window");
  pc_ack_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($rose(o_local_bus_release) && (sel_reg == SEL_PC || sel_reg == SEL_CFG)) |-> ##AK2 $rose(o_ack_n))
    else $error("counter/config ack not two T after release");
  latch_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($rose(o_ack_n) && latched_reg && sel_reg != SEL_DATA_MEMORY) |-> ##HC $fell(o_ad_oe))
    else $error("latched data not held half a T");
  latch_end_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($rose(o_ack_n) && latched_reg) |-> ##T1 $fell(o_local_bus_release)) else $error("latched release not dropped");
  rd_fall_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_mem_read_n) |-> lclr_cyc == 8'(T_CYC)) else $error("memory strobe not one T after release");
  data_memory_ack_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($rose(o_ack_n) && sel_reg == SEL_DATA_MEMORY) |-> lclr_cyc == to_cycles({1'b0, i_wait.data} + 4'h2))
    else $error("data memory ack at wrong time");
  rd_rise_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($rose(o_ack_n) && latched_reg && sel_reg == SEL_DATA_MEMORY) |-> ##HC $rose(o_mem_read_n))
    else $error("memory strobe not lifted half a T after ack");
  ia_step_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ($rose(o_ack_n) && sel_reg == SEL_INSTRUCTION_MEMORY) |-> o_instr_address == $past(o_instr_address) + 16'($past(high_reg)))
    else $error("instruction address stepped wrongly");
  bus_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_local_bus_release |-> !o_addr_oe) else $error("address bus driven during release");

endmodule : remote_read_access_port
`default_nettype wire

//--- core/remote_read_pkg.sv
// shared constants and types for the remote read access port
package remote_read_pkg;

  // clock and T-state timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_STATE_NS    = 50;
  localparam int HALF_T_NS     = 25;
  // whole T-state in clock cycles
  localparam int T_CYC         = T_STATE_NS / CLK_PERIOD_NS;
  // least half T-state, rounded up to whole cycles
  localparam int HALF_T_CYC    = (HALF_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // field widths
  localparam int WAIT_W  = 3;
  localparam int BYTE_W  = 8;
  localparam int IADDR_W = 16;
  localparam int CNT_W   = 4;

  // reset values
  localparam logic [IADDR_W-1:0] IADDR_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0]  DATA_RESET  = 8'h00;

  // read target selected by the host at access start
  typedef enum logic [1:0] {
    SEL_INSTRUCTION_MEMORY,
    SEL_DATA_MEMORY,
    SEL_PC,
    SEL_CFG
  } select_type;

  // host side request strobes, both active low
  typedef struct packed {
    logic       access_n;
    logic       read_n;
    select_type select;
  } remote_req_type;

  // programmable wait T-states
  typedef struct packed {
    logic [WAIT_W-1:0] instr;
    logic [WAIT_W-1:0] data;
    logic [WAIT_W-1:0] local_w;
  } wait_cfg_type;

endpackage : remote_read_pkg

//--- core/tstate_divider.sv
// T-state divider giving full and half T-state enable pulses
`timescale 1ns/10ps
`default_nettype none
module tstate_divider
  import remote_read_pkg::*;
#(
  parameter int PERIOD = T_CYC,
  parameter int HALF   = HALF_T_CYC
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // phase restart at access start
  input  wire logic i_restart,
  // enable pulses
  output var  logic o_t_tick,
  output var  logic o_h_tick
);

  if (PERIOD < 2 || PERIOD > 15 || HALF < 1 || HALF >= PERIOD) begin : g_check
    $error("tstate_divider: unsupported period or half period");
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // restart aligns every later tick to the access start
  always_comb begin
    if (i_restart || cnt_reg == CNT_W'(PERIOD - 1)) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // pulses are suppressed in the restart cycle
  assign o_t_tick = !i_restart && cnt_reg == CNT_W'(PERIOD - 1);
  assign o_h_tick = !i_restart && cnt_reg == CNT_W'(HALF - 1);

endmodule : tstate_divider
`default_nettype wire

//--- verification/remote_host_model.sv
// host processor model that issues remote reads on command
`timescale 1ns/10ps
`default_nettype none
module remote_host_model
  import remote_read_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // command from the bench
  input  wire logic              i_go,
  input  wire select_type        i_sel,
  input  wire logic [3:0]        i_hold,
  // answer from the device
  input  wire logic              i_ack_n,
  input  wire logic [BYTE_W-1:0] i_ad_data,
  // request and result
  output var  remote_req_type    o_req,
  output var  logic [BYTE_W-1:0] o_byte,
  output var  logic              o_done
);
  logic [1:0] st;
  logic [3:0] cnt;

  // strobes and select change together just after an edge
  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    if (!i_nrst) begin
      st <= 2'd0;
      cnt <= 4'h0;
      o_req <= '{1'b1, 1'b1, SEL_INSTRUCTION_MEMORY};
      o_byte <= 8'h00;
    end else begin
      case (st)
        2'd0: if (i_go) begin
          o_req <= '{1'b0, 1'b0, i_sel};
          st <= 2'd1;
        end
        2'd1: if (!i_ack_n) st <= 2'd2;
        // byte taken at the edge that sees ack high
        2'd2: if (i_ack_n) begin
          o_byte <= i_ad_data;
          cnt <= i_hold;
          st <= 2'd3;
        end
        // a long hold stretches a buffered access by whole T-states, up to three
        default: if (cnt == 4'h0) begin
          o_req <= '{1'b1, 1'b1, select_type'(~o_req.select)}; // stale select inverted
          o_done <= 1'b1;
          st <= 2'd0;
        end else cnt <= cnt - 4'h1;
      endcase
    end
  end
endmodule : remote_host_model
`default_nettype wire

//--- verification/remote_read_access_port_tb.sv
// self-checking bench for the remote read access port
`timescale 1ns/10ps
`default_nettype none
module remote_read_access_port_tb;
  import remote_read_pkg::*;
  localparam int T = T_CYC;
  localparam int H = HALF_T_CYC;
  logic           i_clk = 1'b0;
  logic           i_nrst = 1'b0;
  remote_req_type req;
  logic           latched = 1'b0;
  logic           go = 1'b0;
  logic           done;
  wait_cfg_type   wcfg = '0;
  select_type     sel = SEL_INSTRUCTION_MEMORY;
  logic [3:0]     hold = 4'h0;
  logic [15:0]    instruction_memory = 16'h0000;
  logic [15:0]    ia;
  logic [15:0]    exp_ia = 16'h0000;
  logic [7:0]     data_memory = 8'h00, pcv = 8'h00, cfg = 8'h00, ad, got;
  logic           ack_n, rel, ad_oe, addr_oe, rd_n;
  logic           odd = 1'b0;
  int n_errors = 0, compares = 0, cyc = 0, seed = 32'hf6cc;
  int te, taf, tar, tlr, tlf, tor, tof, tmf, tmr, tsr, tae;

  always #5 i_clk = ~i_clk;

  remote_read_access_port DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req), .i_latched_mode(latched),
    .i_wait(wcfg), .i_instruction_memory_rdata(instruction_memory), .i_data_memory_rdata(data_memory), .i_pc_view(pcv), .i_config_reg(cfg),
    .o_ack_n(ack_n), .o_local_bus_release(rel), .o_ad_data(ad), .o_ad_oe(ad_oe),
    .o_instr_address(ia), .o_addr_oe(addr_oe), .o_mem_read_n(rd_n));
  remote_host_model host (.i_clk(i_clk), .i_nrst(i_nrst), .i_go(go), .i_sel(sel), .i_hold(hold),
    .i_ack_n(ack_n), .i_ad_data(ad), .o_req(req), .o_byte(got), .o_done(done));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // stamp every edge; sampled values keep the stamps race free
  always @(posedge i_clk) begin
    cyc++;
    if ($fell(req.access_n)) te = cyc;
    if ($rose(req.access_n)) tsr = cyc;
    if ($fell(ack_n)) taf = cyc;
    if ($rose(ack_n)) tar = cyc;
    if ($rose(rel)) tlr = cyc;
    if ($fell(rel)) tlf = cyc;
    if ($rose(ad_oe)) tor = cyc;
    if ($fell(ad_oe)) tof = cyc;
    if ($fell(rd_n)) tmf = cyc;
    if ($rose(rd_n)) tmr = cyc;
    if ($rose(addr_oe)) tae = cyc;
    if (rel === 1'b1) check(32'(addr_oe), 32'h0);
  end

  task automatic do_read(input select_type s, input logic lat, input logic [3:0] hd, input logic mx);
    int p, a, k;
    logic [7:0] eb;
    @(posedge i_clk);
    latched <= lat;
    sel <= s;
    hold <= hd;
    go <= 1'b1;
    wcfg <= mx ? wait_cfg_type'(9'h1FF) : wait_cfg_type'(9'($random(seed)));
    instruction_memory <= 16'($random(seed));
    data_memory <= 8'($random(seed));
    pcv <= 8'($random(seed));
    cfg <= 8'($random(seed));
    @(posedge i_clk);
    go <= 1'b0;
    for (k = 0; k < 600 && done !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    // a host that never finishes counts as a mismatch
    if (done !== 1'b1) n_errors++;
    // wait for the address bus to come back
    for (k = 0; k < 100 && !(addr_oe === 1'b1 && rel === 1'b0); k++) begin
      @(posedge i_clk);
      #1;
    end
    if (addr_oe !== 1'b1) n_errors++;
    repeat (2) @(posedge i_clk);
    // only a buffered instruction read skips the local wait states
    p = (lat || s != SEL_INSTRUCTION_MEMORY) ? (wcfg.local_w + 1) * T : T;
    a = (s == SEL_INSTRUCTION_MEMORY) ? wcfg.instr + 2 : (s == SEL_DATA_MEMORY) ? wcfg.data + 2 : 2;
    case (s)
      SEL_INSTRUCTION_MEMORY: eb = odd ? instruction_memory[15:8] : instruction_memory[7:0];
      SEL_DATA_MEMORY: eb = data_memory;
      SEL_PC: eb = pcv;
      default: eb = cfg;
    endcase
    // ack is registered at the edge that takes the strobes
    check(taf - te, 1);
    check(tlr - taf, p);
    check(tar - tlr, a * T);
    check(tor - tlr, T);
    check(32'(got), 32'(eb));
    check(tae - tlf, H);
    if (lat) begin
      check(tof - tar, H);
      check(tlf - tar, T);
    end else begin
      check(32'(tof - tsr inside {[1:2]}), 1);
      check(32'(tlf > tsr && tlf - tsr <= T + 1), 1);
    end
    if (s == SEL_DATA_MEMORY) begin
      check(tmf - tlr, T);
      check(tar - tmf, (wcfg.data + 1) * T);
      if (lat) check(tmr - tar, H);
      else check(tmr - tsr, 1);
    end
    if (s == SEL_INSTRUCTION_MEMORY) begin
      if (odd) exp_ia = exp_ia + 16'h0001;
      odd = ~odd;
    end
    check(32'(ia), 32'(exp_ia));
  endtask : do_read

  task automatic summarize();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // corners first, then a random mix
  initial begin
    select_type s;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    #1;
    check(32'(ia), 32'h0);
    check(32'({ack_n, rel, ad_oe, addr_oe, rd_n}), 32'h13);
    do_read(SEL_INSTRUCTION_MEMORY, 1'b0, 4'h0, 1'b0);
    do_read(SEL_INSTRUCTION_MEMORY, 1'b0, 4'h9, 1'b1); // late strobe release
    do_read(SEL_INSTRUCTION_MEMORY, 1'b1, 4'h0, 1'b0);
    for (int i = 0; i < 4; i++) do_read(select_type'(i), 1'b1, 4'h2, 1'b0);
    // buffered style for every target, data memory included
    for (int i = 0; i < 4; i++) do_read(select_type'(i), 1'b0, 4'h1, 1'b0);
    do_read(SEL_DATA_MEMORY, 1'b1, 4'hF, 1'b1);
    for (int i = 0; i < 40; i++) begin
      s = select_type'(2'($random(seed)));
      do_read(s, 1'($random(seed)), 4'($random(seed)) % 4'hA, 1'b0);
    end
    summarize();
  end

  // hang guard well beyond the longest run
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule : remote_read_access_port_tb
`default_nettype wire
